// *** aemif_seq_pkg.sv ***
// Constants, types and configuration layout for the external memory sequencer
// Function
// - Two independent active-low chip selects, each covering a 64 KB address space.
// - External data width selectable per select between 8 and 16 bits.
// - Read without extended wait lasts setup plus strobe plus hold cycles.
// - Extended wait lengthens a read by sixteen cycles per wait count.
// - Normal mode frames strobe by setup/hold; select-strobe mode selects only during strobe, except in burst reads.
// - All phase lengths count peripheral clock periods.
// - NAND mode accumulates single-bit and four-bit error-correction codes over data.
// - Burst mode uses only the 16-bit bus and reads only; a burst write request runs as a read.
// - Burst reads address linearly and continuously; no wrapping.
// - Timing parameters are held separately for each chip select.
// - Burst read data is captured at the rising edge of the driven burst clock.
// - Counts cover turnaround 1-4, setup 1-16, strobe 1-64, hold 1-8, wait 1-256.
// - Write lasts setup plus strobe plus hold, plus sixteen per wait count.
// - Waiting times out once the wait count exceeds the programmed maximum.
// - Strobe ends four cycles after the wait input deasserts.
package aemif_seq_pkg;

  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 16;
  localparam int NUM_CS   = 2;
  localparam int SETUP_W  = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_W   = 3;
  localparam int TA_W     = 2;
  localparam int MAXW_W   = 8;
  localparam int EWC_W    = 9;
  localparam int CNT_W    = 8;
  localparam int BEAT_W   = 8;
  localparam int ECC_IDX_W = 12;

  // Peripheral clock and timing
  localparam int CLK_PERIOD_NS       = 25;
  localparam int BURST_PERIOD_MIN_NS = 15;
  localparam int BURST_HALF_MIN      = (BURST_PERIOD_MIN_NS + 2 * CLK_PERIOD_NS - 1)
                                       / (2 * CLK_PERIOD_NS);
  localparam int SYNC_STAGES         = 2;
  localparam int WAIT_END_CYCLES     = 4;
  localparam logic [CNT_W-1:0] WAIT_END_LOAD = CNT_W'(WAIT_END_CYCLES - SYNC_STAGES - 1);
  localparam logic [3:0]       WAIT_UNIT_LAST = 4'hf;

  // Four-bit code feedback polynomial
  localparam logic [DATA_W-1:0] ECC_POLY = 16'h8005;

  typedef enum logic [7:0] {
    S_IDLE    = 8'h01,
    S_SETUP   = 8'h02,
    S_STROBE  = 8'h04,
    S_WAITX   = 8'h08,
    S_WAITEND = 8'h10,
    S_HOLD    = 8'h20,
    S_TURN    = 8'h40,
    S_BURST   = 8'h80
  } state_t;

  // Per-select timing, all counts stored as cycles minus one
  typedef struct packed {
    logic                nand_mode;
    logic                select_strobe;
    logic                extended_wait_enable;
    logic                bus_16bit;
    logic [SETUP_W-1:0]  read_setup_cycles;
    logic [STROBE_W-1:0] read_strobe_cycles;
    logic [HOLD_W-1:0]   read_hold_cycles;
    logic [SETUP_W-1:0]  write_setup_cycles;
    logic [STROBE_W-1:0] write_strobe_cycles;
    logic [HOLD_W-1:0]   write_hold_cycles;
    logic [TA_W-1:0]     turnaround_cycles;
  } cs_cfg_t;

  typedef struct packed {
    logic              write;
    logic              burst;
    logic              cs;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BEAT_W-1:0] beats;
  } req_t;

endpackage

// *** async_ext_memory_sequencer.sv ***
// Setup/strobe/hold sequencer for asynchronous and burst external memory
`timescale 1ns/10ps
module async_ext_memory_sequencer
  import aemif_seq_pkg::*;
#(
  parameter int BURST_HALF = (BURST_HALF_MIN > 2) ? BURST_HALF_MIN : 2
) (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  srst_in,
  // Configuration and status
  input  wire cs_cfg_t [NUM_CS-1:0]  cfg_in,
  input  wire logic [MAXW_W-1:0]     max_wait_cycles_in,
  input  wire logic                  timeout_clear_in,
  input  wire logic                  ecc_clear_in,
  output logic                       busy_out,
  output logic                       timeout_out,
  output logic [2*ECC_IDX_W-1:0]     ecc_1bit_out,
  output logic [DATA_W-1:0]          ecc_4bit_out,
  // Request side
  input  wire logic                  req_valid_in,
  output logic                       req_ready_out,
  input  wire req_t                  req_in,
  // Read data side
  output logic                       rd_valid_out,
  input  wire logic                  rd_ready_in,
  output logic [DATA_W-1:0]          rd_data_out,
  // External memory pins
  output logic [NUM_CS-1:0]          chip_select_n_out,
  output logic                       read_strobe_n_out,
  output logic                       write_strobe_n_out,
  output logic [13:0]                ext_address_bus_out,
  output logic [1:0]                 ext_bank_address_out,
  input  wire logic [DATA_W-1:0]     ext_data_bus_in,
  output logic [DATA_W-1:0]          ext_data_bus_out,
  output logic                       ext_data_bus_oe_out,
  input  wire logic                  ext_wait_in,
  output logic                       burst_clock_out
);
  typedef struct packed {
    state_t              state;
    logic [CNT_W-1:0]    cnt;
    logic [3:0]          sub;
    logic [EWC_W-1:0]    ext_wait_count;
    logic                waited;
    req_t                req;
    cs_cfg_t             cfg;
    logic [DATA_W-1:0]   rdata;
    logic                push;
    logic                wsync1;
    logic                wsync2;
    logic [DATA_W-1:0]   dsync1;
    logic [DATA_W-1:0]   dsync2;
    logic                bclk;
    logic [CNT_W-1:0]    bdiv;
    logic [1:0]          rise_d;
    logic [BEAT_W-1:0]   beats;
    logic                timeout;
    logic [2*ECC_IDX_W-1:0] ecc1;
    logic [DATA_W-1:0]   ecc4;
    logic [ECC_IDX_W-1:0] eidx;
    logic [9:0]          acc_len;
  } st_t;

  localparam st_t RESET_ST = '{state: S_IDLE, default: '0};

  st_t                    st_r;
  st_t                    st_nxt;
  logic                   buf_ready;
  logic                   in_acc;
  logic                   strobe_ph;
  logic                   cs_act;
  logic                   ev;
  logic                   strobe_done;
  logic [DATA_W-1:0]      word;
  logic [2*ECC_IDX_W-1:0] ecc1_flip;
  logic [DATA_W-1:0]      ecc4_f;
  logic [DATA_W-1:0]      ecc4_step;
  logic                   word_par;

  // Read data buffer
  rdbuf_two_entry #(.W(DATA_W), .DEPTH(2)) u_rdbuf (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .in_valid_in   (st_r.push),
    .in_ready_out  (buf_ready),
    .in_data_in    (st_r.rdata),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  // Row parity pairs per word-index bit
  assign word_par = ^word;
  for (genvar k = 0; k < ECC_IDX_W; k++) begin : g_ecc1
    assign ecc1_flip[k]             = word_par & st_r.eidx[k];
    assign ecc1_flip[ECC_IDX_W + k] = word_par & ~st_r.eidx[k];
  end
  assign ecc4_f    = (ecc_clear_in ? '0 : st_r.ecc4) ^ word;
  assign ecc4_step = {ecc4_f[DATA_W-2:0], 1'b0} ^ (ecc4_f[DATA_W-1] ? ECC_POLY : '0);

  always_comb begin
    st_nxt = st_r;
    ev = 1'b0;
    strobe_done = 1'b0;
    word = '0;
    st_nxt.push = 1'b0;
    st_nxt.wsync1 = ext_wait_in;
    st_nxt.wsync2 = st_r.wsync1;
    st_nxt.dsync1 = ext_data_bus_in;
    st_nxt.dsync2 = st_r.dsync1;
    st_nxt.rise_d = {st_r.rise_d[0], 1'b0};
    if (timeout_clear_in) begin
      st_nxt.timeout = 1'b0;
    end
    if (ecc_clear_in) begin
      st_nxt.ecc1 = '0;
      st_nxt.ecc4 = '0;
      st_nxt.eidx = '0;
    end
    case (st_r.state)
      S_IDLE: begin
        if (req_valid_in && req_ready_out) begin
          st_nxt.req = req_in;
          st_nxt.cfg = cfg_in[req_in.cs];
          if (req_in.burst) begin
            st_nxt.cfg.bus_16bit = 1'b1;
            st_nxt.req.write = 1'b0;
          end
          st_nxt.state = S_SETUP;
          st_nxt.cnt = CNT_W'(req_in.write && !req_in.burst ?
                       cfg_in[req_in.cs].write_setup_cycles :
                       cfg_in[req_in.cs].read_setup_cycles);
          st_nxt.acc_len = '0;
          st_nxt.waited = 1'b0;
          st_nxt.beats = '0;
          st_nxt.ext_wait_count = '0;
          st_nxt.bdiv = '0;
        end
      end
      S_SETUP: begin
        st_nxt.acc_len = 10'(st_r.acc_len + 1'b1);
        if (st_r.cnt == '0) begin
          if (st_r.req.burst) begin
            st_nxt.state = S_BURST;
          end else begin
            st_nxt.state = S_STROBE;
            st_nxt.cnt = CNT_W'(st_r.req.write ? st_r.cfg.write_strobe_cycles :
                                                 st_r.cfg.read_strobe_cycles);
            ev = st_r.req.write;
            word = st_r.req.wdata;
          end
        end else begin
          st_nxt.cnt = CNT_W'(st_r.cnt - 1'b1);
        end
      end
      S_STROBE: begin
        st_nxt.acc_len = 10'(st_r.acc_len + 1'b1);
        if (st_r.cnt != '0) begin
          st_nxt.cnt = CNT_W'(st_r.cnt - 1'b1);
        end else if (st_r.cfg.extended_wait_enable && st_r.wsync2) begin
          st_nxt.state = S_WAITX;
          st_nxt.sub = '0;
          st_nxt.ext_wait_count = '0;
          st_nxt.waited = 1'b1;
        end else begin
          strobe_done = 1'b1;
        end
      end
      S_WAITX: begin
        st_nxt.sub = 4'(st_r.sub + 1'b1);
        st_nxt.ext_wait_count = EWC_W'(st_r.ext_wait_count + (st_r.sub == WAIT_UNIT_LAST));
        if (!st_r.wsync2) begin
          st_nxt.state = S_WAITEND;
          st_nxt.cnt = WAIT_END_LOAD;
        end else if (st_r.ext_wait_count > EWC_W'(max_wait_cycles_in)) begin
          st_nxt.timeout = 1'b1;
          strobe_done = 1'b1;
        end
      end
      S_WAITEND: begin
        if (st_r.cnt == '0) begin
          strobe_done = 1'b1;
        end else begin
          st_nxt.cnt = CNT_W'(st_r.cnt - 1'b1);
        end
      end
      S_HOLD: begin
        st_nxt.acc_len = 10'(st_r.acc_len + 1'b1);
        if (st_r.cnt == '0) begin
          st_nxt.state = S_TURN;
          st_nxt.cnt = CNT_W'(st_r.cfg.turnaround_cycles);
        end else begin
          st_nxt.cnt = CNT_W'(st_r.cnt - 1'b1);
        end
      end
      S_TURN: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = S_IDLE;
        end else begin
          st_nxt.cnt = CNT_W'(st_r.cnt - 1'b1);
        end
      end
      S_BURST: begin
        st_nxt.bdiv = CNT_W'(st_r.bdiv + 1'b1);
        if (st_r.bdiv == CNT_W'(BURST_HALF - 1)) begin
          st_nxt.bdiv = '0;
          if (st_r.bclk) begin
            st_nxt.bclk = 1'b0;
          end else if (st_r.beats != st_r.req.beats && buf_ready) begin
            st_nxt.bclk = 1'b1;
            st_nxt.rise_d[0] = 1'b1;
          end
        end
        if (st_r.rise_d[1]) begin
          st_nxt.push = 1'b1;
          st_nxt.rdata = st_r.dsync2;
          ev = 1'b1;
          word = st_r.dsync2;
          st_nxt.beats = BEAT_W'(st_r.beats + 1'b1);
          st_nxt.req.addr = ADDR_W'(st_r.req.addr + 2'd2);
        end else if (st_r.beats == st_r.req.beats && !st_r.bclk && st_r.rise_d == '0) begin
          st_nxt.state = S_HOLD;
          st_nxt.bdiv = '0;
          st_nxt.cnt = CNT_W'(st_r.cfg.read_hold_cycles);
        end
      end
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase
    if (strobe_done) begin
      st_nxt.state = S_HOLD;
      st_nxt.cnt = CNT_W'(st_r.req.write ? st_r.cfg.write_hold_cycles :
                                           st_r.cfg.read_hold_cycles);
      if (!st_r.req.write) begin
        st_nxt.push = 1'b1;
        st_nxt.rdata = st_r.cfg.bus_16bit ? st_r.dsync2 : {8'h00, st_r.dsync2[7:0]};
        ev = 1'b1;
        word = st_nxt.rdata;
      end
    end
    if (ev && st_r.cfg.nand_mode) begin
      st_nxt.ecc1 = (ecc_clear_in ? '0 : st_r.ecc1) ^ ecc1_flip;
      st_nxt.ecc4 = ecc4_step;
      st_nxt.eidx = ECC_IDX_W'((ecc_clear_in ? '0 : st_r.eidx) + 1'b1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r <= RESET_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drive
  assign in_acc    = (st_r.state & (S_SETUP | S_STROBE | S_WAITX | S_WAITEND |
                                    S_HOLD | S_BURST)) != '0;
  assign strobe_ph = (st_r.state & (S_STROBE | S_WAITX | S_WAITEND | S_BURST)) != '0;
  assign cs_act    = (st_r.cfg.select_strobe && !st_r.req.burst) ? strobe_ph : in_acc;
  assign chip_select_n_out  = {!(cs_act && st_r.req.cs), !(cs_act && !st_r.req.cs)};
  assign read_strobe_n_out  = !(strobe_ph && !st_r.req.write);
  assign write_strobe_n_out = !(strobe_ph && st_r.req.write);
  assign {ext_bank_address_out, ext_address_bus_out} =
    st_r.cfg.bus_16bit ? {1'b0, st_r.req.addr[ADDR_W-1:1]} : st_r.req.addr;
  assign ext_data_bus_out    = st_r.cfg.bus_16bit ? st_r.req.wdata :
                                                    {8'h00, st_r.req.wdata[7:0]};
  assign ext_data_bus_oe_out = in_acc && st_r.req.write;
  assign burst_clock_out     = st_r.bclk;
  assign req_ready_out       = (st_r.state == S_IDLE) && buf_ready;
  assign busy_out            = (st_r.state != S_IDLE);
  assign timeout_out         = st_r.timeout;
  assign ecc_1bit_out        = st_r.ecc1;
  assign ecc_4bit_out        = st_r.ecc4;

  AST_CS_EXCLUSIVE: assert property (@(posedge clock_in) disable iff (srst_in)
    chip_select_n_out != 2'b00) else $error("both chip selects active");
  AST_CYCLE_LEN: assert property (@(posedge clock_in) disable iff (srst_in)
    (st_r.state == S_HOLD && st_r.cnt == '0 && !st_r.waited && !st_r.req.burst) |->
    st_r.acc_len == 10'(st_r.req.write ?
      st_r.cfg.write_setup_cycles + st_r.cfg.write_strobe_cycles + st_r.cfg.write_hold_cycles :
      st_r.cfg.read_setup_cycles + st_r.cfg.read_strobe_cycles + st_r.cfg.read_hold_cycles) + 10'd2)
    else $error("access length wrong");
  AST_SS_SELECT: assert property (@(posedge clock_in) disable iff (srst_in)
    (in_acc && st_r.cfg.select_strobe && !st_r.req.burst) |->
    ((chip_select_n_out == 2'b11) == (read_strobe_n_out && write_strobe_n_out)))
    else $error("select-strobe framing wrong");
  AST_SETUP_LEAD: assert property (@(posedge clock_in) disable iff (srst_in)
    ($fell(read_strobe_n_out) && !st_r.cfg.select_strobe) |->
    $past(chip_select_n_out != 2'b11, 1)) else $error("select not ahead of strobe");
  AST_WAIT_END: assert property (@(posedge clock_in) disable iff (srst_in)
    (st_r.state == S_WAITX && !st_r.wsync2) |=>
    (st_r.state == S_WAITEND) [*2] ##1 (st_r.state == S_HOLD)) else $error("wait end late");
  AST_TIMEOUT: assert property (@(posedge clock_in) disable iff (srst_in)
    $rose(timeout_out) |-> $past(st_r.state == S_WAITX) && st_r.state == S_HOLD)
    else $error("timeout outside wait");
  AST_TURN_IDLE: assert property (@(posedge clock_in) disable iff (srst_in)
    (st_r.state == S_TURN) |-> (chip_select_n_out == 2'b11 && read_strobe_n_out &&
    write_strobe_n_out && !ext_data_bus_oe_out)) else $error("turnaround not idle");
  AST_ADDR_STABLE: assert property (@(posedge clock_in) disable iff (srst_in)
    (in_acc && $past(in_acc) && !st_r.req.burst) |->
    ($stable(ext_address_bus_out) && $stable(ext_bank_address_out) &&
     ($stable(chip_select_n_out) || st_r.cfg.select_strobe)))
    else $error("address moved in access");
  AST_BURST_CAPTURE: assert property (@(posedge clock_in) disable iff (srst_in)
    (st_r.push && st_r.state == S_BURST) |->
    ($past(burst_clock_out, 2) && !$past(burst_clock_out, 3)))
    else $error("burst capture not on rising edge");
  AST_BURST_LINEAR: assert property (@(posedge clock_in) disable iff (srst_in)
    (st_r.state == S_BURST && $past(st_r.state) == S_BURST && $changed(st_r.req.addr)) |->
    st_r.req.addr == ADDR_W'($past(st_r.req.addr) + 2'd2)) else $error("burst address wrapped");
endmodule // async_ext_memory_sequencer

// *** async_ext_memory_sequencer_tb.sv ***
// Testbench for the external memory sequencer
`timescale 1ns/10ps
module async_ext_memory_sequencer_tb;
  import aemif_seq_pkg::*;
  logic                   clock_in = 0, srst_in = 1, tclr = 0, eclr = 0, rvalid = 0, rdy = 1;
  cs_cfg_t [NUM_CS-1:0]   cfg;
  logic [MAXW_W-1:0]      maxw = 8'hff;
  req_t                   req = '0;
  logic                   busy, tout, qrdy, dvalid, oe, rs_n, ws_n, bclk, wt, seen, bprev, cprev;
  logic [2*ECC_IDX_W-1:0] e1;
  logic [15:0]            e4, rdat, dout, din, wd, ad;
  logic [1:0]             cs_n, ba, csw;
  logic [13:0]            a;
  logic [7:0]             wlen = 0;
  int                     err_total = 0, tests_run = 0;
  int                     n_cs, n_rs, n_ws, n_pre, n_aft, n_bc, n_ta;
  logic [15:0]            q[$];

  always #12.5 clock_in = ~clock_in;

  async_ext_memory_sequencer uut (.clock_in(clock_in), .srst_in(srst_in), .cfg_in(cfg),
    .max_wait_cycles_in(maxw), .timeout_clear_in(tclr), .ecc_clear_in(eclr), .busy_out(busy),
    .timeout_out(tout), .ecc_1bit_out(e1), .ecc_4bit_out(e4), .req_valid_in(rvalid),
    .req_ready_out(qrdy), .req_in(req), .rd_valid_out(dvalid), .rd_ready_in(rdy),
    .rd_data_out(rdat), .chip_select_n_out(cs_n), .read_strobe_n_out(rs_n),
    .write_strobe_n_out(ws_n), .ext_address_bus_out(a), .ext_bank_address_out(ba),
    .ext_data_bus_in(din), .ext_data_bus_out(dout), .ext_data_bus_oe_out(oe),
    .ext_wait_in(wt), .burst_clock_out(bclk));

  ext_mem_model mem (.clock_in(clock_in), .chip_select_n_in(cs_n), .read_strobe_n_in(rs_n),
    .write_strobe_n_in(ws_n), .addr_in({ba, a}), .data_out(din), .wait_out(wt),
    .wait_len_in(wlen));

  // Pin monitor, counts phases of the current access
  initial begin
    cprev = 1;
    bprev = 0;
  end
  always @(posedge clock_in) begin
    if (dvalid === 1 && rdy) q.push_back(rdat);
    if (bclk && !bprev) n_bc++;
    bprev = bclk;
    if (wt) seen = 1;
    if (!(&cs_n)) begin
      n_cs++;
      if (!rs_n) begin
        n_rs++;
        ad = {ba, a};
        csw = cs_n;
      end
      if (!ws_n) begin
        n_ws++;
        wd = oe ? dout : 16'hxxxx;
      end
      if (rs_n && ws_n && n_rs + n_ws == 0) n_pre++;
      if (!rs_n && !wt && seen) n_aft++;
    end else if (busy && n_cs > 0 && rs_n && ws_n) begin
      n_ta++;
    end
  end

  function automatic logic [15:0] mdat(input logic [15:0] x);
    return 16'h5a00 ^ x;
  endfunction
  function automatic logic [15:0] pop();
    if (q.size() == 0) return 16'hxxxx;
    return q.pop_front();
  endfunction

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // One access through the request handshake, then wait for idle
  task automatic acc(input logic w, b, c, input logic [15:0] ai, d, input logic [7:0] bt);
    int k;
    n_cs = 0;
    n_rs = 0;
    n_ws = 0;
    n_pre = 0;
    n_aft = 0;
    n_bc = 0;
    n_ta = 0;
    seen = 0;
    @(posedge clock_in);
    rvalid <= 1;
    req <= '{w, b, c, ai, d, bt};
    @(negedge clock_in);
    for (k = 0; k < 500 && qrdy !== 1; k++) @(negedge clock_in);
    chkn(k, 0, 499);
    @(posedge clock_in);
    rvalid <= 0;
    @(negedge clock_in);
    for (k = 0; k < 2000 && busy !== 0; k++) @(negedge clock_in);
    chkn(k, 0, 1999);
    repeat (3) @(negedge clock_in);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    end_of_test();
  end

  initial begin
    cfg[0] = '{1'b0, 1'b0, 1'b0, 1'b1, 4'h2, 6'h03, 3'h1, 4'h1, 6'h02, 3'h2, 2'h1};
    cfg[1] = '{1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 6'h03, 3'h0, 4'h0, 6'h00, 3'h0, 2'h3};
    repeat (20) @(posedge clock_in);
    srst_in <= 0;
    @(negedge clock_in);
    chk16({12'h0, cs_n, busy, qrdy}, 16'h000d);
    // Normal read, 16-bit, select 0
    acc(0, 0, 0, 16'h1234, 16'h0, 8'h0);
    chkn(n_pre, 3, 3);
    chkn(n_rs, 4, 4);
    chkn(n_cs, 9, 9);
    chkn(n_ta, 2, 2);
    chk16(ad, 16'h091a);
    chk16({14'h0, csw}, 16'h0002);
    chk16(pop(), mdat(16'h091a));
    // Select-strobe read, 8-bit, select 1
    acc(0, 0, 1, 16'h00a5, 16'h0, 8'h0);
    chkn(n_pre, 0, 0);
    chkn(n_cs, 4, 4);
    chk16({14'h0, csw}, 16'h0001);
    chk16(pop(), mdat(16'h00a5) & 16'h00ff);
    // Write
    acc(1, 0, 0, 16'h0010, 16'hbeef, 8'h0);
    chkn(n_cs, 8, 8);
    chkn(n_ws, 3, 3);
    chkn(n_ta, 2, 2);
    chk16(wd, 16'hbeef);
    // Extended wait
    @(posedge clock_in);
    cfg[0].extended_wait_enable <= 1;
    cfg[0].read_strobe_cycles <= 6'h07;
    wlen <= 8'd20;
    acc(0, 0, 0, 16'h0000, 16'h0, 8'h0);
    chkn(n_rs, 24, 40);
    chkn(n_aft, 3, 5);
    chk16({15'h0, tout}, 16'h0000);
    void'(pop());
    // Wait beyond the limit
    @(posedge clock_in);
    maxw <= 8'h00;
    wlen <= 8'd100;
    acc(0, 0, 0, 16'h0000, 16'h0, 8'h0);
    chk16({15'h0, tout}, 16'h0001);
    chkn(n_rs, 8, 60);
    void'(pop());
    @(posedge clock_in);
    tclr <= 1;
    maxw <= 8'hff;
    wlen <= 8'd0;
    cfg[0].extended_wait_enable <= 0;
    cfg[0].read_strobe_cycles <= 6'h03;
    @(posedge clock_in);
    tclr <= 0;
    @(negedge clock_in);
    chk16({15'h0, tout}, 16'h0000);
    // Read buffer stalled by the receiver
    @(posedge clock_in);
    rdy <= 0;
    acc(0, 0, 0, 16'h0002, 16'h0, 8'h0);
    acc(0, 0, 0, 16'h0004, 16'h0, 8'h0);
    chk16({15'h0, qrdy}, 16'h0000);
    @(posedge clock_in);
    rdy <= 1;
    repeat (4) @(negedge clock_in);
    chk16(pop(), mdat(16'h0001));
    chk16(pop(), mdat(16'h0002));
    // Burst read on the 8-bit select, forced to 16-bit
    acc(0, 1, 1, 16'h0100, 16'h0, 8'h03);
    chkn(n_bc, 3, 3);
    for (int k = 0; k < 3; k++) chk16(pop(), mdat(16'h0080 + 16'(k)));
    // Error-correction codes over a write
    @(posedge clock_in);
    cfg[0].nand_mode <= 1;
    acc(1, 0, 0, 16'h0020, 16'h00fe, 8'h0);
    chk16({15'h0, |e4}, 16'h0001);
    chk16(e1[23:8], 16'hfff0);
    @(posedge clock_in);
    eclr <= 1;
    @(posedge clock_in);
    eclr <= 0;
    @(negedge clock_in);
    chk16(e4 | e1[15:0] | {8'h0, e1[23:16]}, 16'h0000);
    end_of_test();
  end
endmodule // async_ext_memory_sequencer_tb

// *** ext_mem_model.sv ***
// External memory model with data and wait behaviour
`timescale 1ns/10ps
module ext_mem_model
  import aemif_seq_pkg::*;
(
  // Clock
  input  wire logic              clock_in,
  // Memory pins
  input  wire logic [NUM_CS-1:0] chip_select_n_in,
  input  wire logic              read_strobe_n_in,
  input  wire logic              write_strobe_n_in,
  input  wire logic [15:0]       addr_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   wait_out,
  // Test control
  input  wire logic [7:0]        wait_len_in
);
  logic [15:0] last_r;
  logic        rs_prev_r;
  int          wcnt;
  initial begin
    data_out = 16'h0;
    wait_out = 1'b0;
    last_r = 16'h0;
    rs_prev_r = 1'b1;
    wcnt = 0;
  end
  always @(posedge clock_in) begin
    // Data from address while selected and not writing, toggling junk otherwise
    if (!(&chip_select_n_in) && write_strobe_n_in) begin
      last_r = 16'h5a00 ^ addr_in;
    end else begin
      last_r = ~last_r;
    end
    data_out <= last_r;
    // Wait raised one cycle into read strobe, held at least two cycles
    if (&chip_select_n_in) begin
      wcnt = 0;
    end else if (!read_strobe_n_in && rs_prev_r && wait_len_in > 8'h01) begin
      wcnt = int'(wait_len_in);
    end else if (wcnt > 0) begin
      wcnt--;
    end
    wait_out <= (wcnt > 0);
    rs_prev_r = read_strobe_n_in;
  end
endmodule // ext_mem_model

// *** rdbuf_two_entry.sv ***
// Small valid/ready buffer for read data
`timescale 1ns/10ps
module rdbuf_two_entry #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         srst_in,
  // Fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           count;
  } buf_t;

  buf_t st_r;
  buf_t st_nxt;
  logic push;
  logic pop;

  assign in_ready_out  = (st_r.count != CW'(DEPTH));
  assign out_valid_out = (st_r.count != '0);
  assign out_data_out  = st_r.mem[st_r.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_in;
      st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : PW'(st_r.wp + 1'b1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : PW'(st_r.rp + 1'b1);
    end
    if (push && !pop) begin
      st_nxt.count = CW'(st_r.count + 1'b1);
    end else if (pop && !push) begin
      st_nxt.count = CW'(st_r.count - 1'b1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // rdbuf_two_entry
